// ===== common/scrc_map.vh
// Register map, field positions, reset values and timing counts for the config block.
`ifndef SCRC_MAP_VH
`define SCRC_MAP_VH
// Register indices; byte address is four times the index.
`define SCRC_IDX_OPTIONS 10'h039
`define SCRC_IDX_CONFIG 10'h03f
`define SCRC_IDX_STATUS 10'h040
// System options fields.
`define SCRC_OPT_CONV 7
`define SCRC_OPT_CLKSRC 6
`define SCRC_OPT_IRQS 5
`define SCRC_OPT_STARTUP 4
`define SCRC_OPT_MONEN 3
`define SCRC_OPT_MONFORCE 2
`define SCRC_OPT_RATE_HI 1
`define SCRC_OPT_RATE_LO 0
`define SCRC_OPT_RESET 8'h10
// Time protected fields: sense, delay, forced monitor, rate.
`define SCRC_OPT_TP_MASK 8'h37
// Nonvolatile config fields; bits 7, 6 and 1 always read one.
`define SCRC_CFG_AUXCLK 5
`define SCRC_CFG_PULLUP 4
`define SCRC_CFG_NOSECURE 3
`define SCRC_CFG_NOWDOG 2
`define SCRC_CFG_NVMAP 0
`define SCRC_CFG_ONES 8'hc2
// Write window after reset release, in bus cycles.
`define SCRC_WINDOW_CYCLES 7'h40
// Start-up delays in bus cycles.
`define SCRC_RESTART_LONG 12'hfe0
`define SCRC_RESTART_SHORT 12'h004
// Reset causes.
`define SCRC_CAUSE_PIN 2'h0
`define SCRC_CAUSE_CLKMON 2'h1
`define SCRC_CAUSE_WDOG 2'h2
// Vector addresses.
`define SCRC_VEC_PIN 16'hfffe
`define SCRC_VEC_CLKMON 16'hfffc
`define SCRC_VEC_WDOG 16'hfffa
`define SCRC_VEC_SPECIAL_HI 8'hbf
// Watchdog prescale exponent and rate scales.
`define SCRC_WDOG_EXP 5'h0f
`define SCRC_SCALE_1 7'h01
`define SCRC_SCALE_4 7'h04
`define SCRC_SCALE_16 7'h10
`define SCRC_SCALE_64 7'h40
// Memory map reset values.
`define SCRC_INIT_MAP_RESET 8'h00
`define SCRC_RAM_BASE 16'h00a0
`define SCRC_RAM_TOP 16'h039f
`define SCRC_REG_TOP 16'h009f
`define SCRC_NV_BASE 16'h0d80
`define SCRC_NV_TOP 16'h0fff
`define SCRC_COMPARE_RESET 16'hffff
// Bus responses.
`define SCRC_RESP_OKAY 2'h0
`define SCRC_RESP_SLVERR 2'h2
`endif

// ===== logic/scrc_top.v
// System configuration and reset control block with an AXI4-Lite register slave.
// Behaviour
// - Options register resets to 0x10.
// - Protected fields writable once within 64 cycles.
// - Special mode lifts the protected-field limits.
// - Converter power field enables the converter.
// - Clock select routes RC clock to converter.
// - Interrupt pin falling-edge or low-level sensitive.
// - Delay field selects long or four-cycle restart.
// - Clock monitor enable free, cleared by reset.
// - Forced monitor holds monitoring until reset.
// - Watchdog rate scales E clock over 2^15.
// - Working latches loaded from cells at reset.
// - Programmed value shows only after next reset.
// - Special mode writes latches, else programming.
// - Config bits 7, 6, 1 read one.
// - Aux clock pin enable and pull-up enable.
// - Watchdog disable, memory map, security fields.
// - Vector chosen from reset cause and mode.
// - CPU fetches vector, masks X, I, stop.
// - Memory map registers reset to fixed layout.
// - Expanded mode gives B, C, F to bus.
// - First timer counters, masks, compares reset.
// - Second, third timers reset, channel four compare.
// - Rate codes scale by 1, 4, 16, 64.
//
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
`include "scrc_map.vh"
module scrc_top (
  input wire aclk,
  input wire aresetn,
  input wire [11:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [11:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire [1:0] reset_cause,
  input wire special_mode_flag,
  input wire expanded_mode,
  input wire [7:0] nv_cells,
  input wire stop_exit,
  input wire aux_clock,
  output reg [7:0] nv_prog_data,
  output reg nv_prog_strobe,
  output reg cpu_resume,
  output reg converter_power,
  output reg clock_source_select,
  output reg interrupt_pin_sense,
  output reg startup_delay_enable,
  output reg clock_monitor_active,
  output reg [1:0] watchdog_rate,
  output reg [6:0] watchdog_scale,
  output reg [4:0] watchdog_prescale_exp,
  output reg aux_clock_pin,
  output reg aux_clock_pin_oe,
  output reg pullup_assign_enable,
  output reg security_disable,
  output reg watchdog_disable,
  output reg nonvolatile_map_enable,
  output reg [15:0] vector_addr,
  output reg vector_fetch,
  output reg condition_codes_mask_x,
  output reg condition_codes_mask_i,
  output reg condition_codes_stop_inhibit,
  output reg [7:0] init_map,
  output reg [15:0] ram_base,
  output reg [15:0] ram_top,
  output reg [15:0] reg_top,
  output reg [15:0] nv_base,
  output reg [15:0] nv_top,
  output reg ports_bcf_to_bus,
  output reg ports_all_inputs,
  output reg timer_init,
  output reg [15:0] compare_init_value,
  output reg [7:0] compare_one_output_mask,
  output reg capture4_compare5_select,
  output reg ext_clock_enable_a,
  output reg ext_clock_enable_b,
  output reg channel4_is_compare
);

  reg [7:0] options_r;
  reg [7:0] options_nxt;
  reg [7:0] config_r;
  reg [6:0] window_cnt_r;
  reg window_open_r;
  reg tp_written_r;
  reg special_r;
  reg [1:0] cause_r;
  reg in_reset_r;
  reg aw_got_r;
  reg w_got_r;
  reg [9:0] aw_idx_r;
  reg [31:0] wdata_r;
  reg [3:0] wstrb_r;
  reg [11:0] restart_cnt_r;
  reg restart_busy_r;
  reg forced_seen_r;
  reg [31:0] rdata_nxt;
  reg rmapped;
  reg [15:0] vector_nxt;
  wire [9:0] ar_idx;
  wire wr_do;
  wire wr_lane0;
  wire wr_opt;
  wire wr_cfg;
  wire tp_open;

  assign s_axi_awready = !aw_got_r && !s_axi_bvalid;
  assign s_axi_wready = !w_got_r && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign ar_idx = s_axi_araddr[11:2];
  assign wr_do = aw_got_r && w_got_r && !s_axi_bvalid;
  assign wr_lane0 = wr_do && wstrb_r[0];
  assign wr_opt = wr_lane0 && (aw_idx_r == `SCRC_IDX_OPTIONS);
  assign wr_cfg = wr_lane0 && (aw_idx_r == `SCRC_IDX_CONFIG);
  // Protected fields are open in special mode, or once inside the window.
  assign tp_open = special_r || (window_open_r && !tp_written_r);

  // Next options value: free fields always, protected fields only while open.
  always @* begin
    options_nxt = options_r;
    if (wr_opt) begin
      options_nxt = wdata_r[7:0] & ~`SCRC_OPT_TP_MASK;
      if (tp_open) begin
        options_nxt = wdata_r[7:0];
      end else begin
        options_nxt = options_nxt | (options_r & `SCRC_OPT_TP_MASK);
      end
    end
  end

  // Vector from cause and mode; special modes use the high page of the boot area.
  always @* begin
    case (cause_r)
      `SCRC_CAUSE_CLKMON: vector_nxt = `SCRC_VEC_CLKMON;
      `SCRC_CAUSE_WDOG: vector_nxt = `SCRC_VEC_WDOG;
      default: vector_nxt = `SCRC_VEC_PIN;
    endcase
    if (special_r) begin
      vector_nxt = {`SCRC_VEC_SPECIAL_HI, vector_nxt[7:0]};
    end
  end

  // Options register, write window counter and single-write tracking.
  always @(posedge aclk) begin
    if (!aresetn) begin
      options_r <= `SCRC_OPT_RESET;
      window_cnt_r <= 7'h00;
      window_open_r <= 1'b1;
      tp_written_r <= 1'b0;
    end else begin
      options_r <= options_nxt;
      if (window_open_r) begin
        window_cnt_r <= window_cnt_r + 7'h01;
        if (window_cnt_r == `SCRC_WINDOW_CYCLES - 7'h01) begin
          window_open_r <= 1'b0;
        end
      end
      if (wr_opt && window_open_r && !special_r) begin
        tp_written_r <= 1'b1;
      end
    end
  end

  // Working latches reload from the cells while reset is held.
  always @(posedge aclk) begin
    if (!aresetn) begin
      config_r <= nv_cells | `SCRC_CFG_ONES;
      special_r <= special_mode_flag;
      cause_r <= reset_cause;
      nv_prog_data <= 8'h00;
      nv_prog_strobe <= 1'b0;
    end else begin
      nv_prog_strobe <= 1'b0;
      if (wr_cfg) begin
        if (special_r) begin
          config_r <= wdata_r[7:0] | `SCRC_CFG_ONES;
        end else begin
          nv_prog_data <= wdata_r[7:0];
          nv_prog_strobe <= 1'b1;
        end
      end
    end
  end

  // Write channels are captured in either order; the response follows both.
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      aw_idx_r <= 10'h000;
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SCRC_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_r <= 1'b1;
        aw_idx_r <= s_axi_awaddr[11:2];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (wr_do) begin
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (aw_idx_r == `SCRC_IDX_OPTIONS || aw_idx_r == `SCRC_IDX_CONFIG) begin
          s_axi_bresp <= `SCRC_RESP_OKAY;
        end else begin
          s_axi_bresp <= `SCRC_RESP_SLVERR;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read mux; status shows vector, cause, mode and window state.
  always @* begin
    rdata_nxt = 32'h00000000;
    rmapped = 1'b1;
    case (ar_idx)
      `SCRC_IDX_OPTIONS: rdata_nxt = {24'h000000, options_r};
      `SCRC_IDX_CONFIG: rdata_nxt = {24'h000000, config_r};
      `SCRC_IDX_STATUS: rdata_nxt = {vector_addr, 11'h000, special_r, cause_r,
                                     tp_written_r, window_open_r};
      default: rmapped = 1'b0;
    endcase
  end

  // Read channel: one answer per accepted address.
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `SCRC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rdata_nxt;
      s_axi_rresp <= rmapped ? `SCRC_RESP_OKAY : `SCRC_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Restart after stop: long stabilisation delay or about four cycles.
  // A stop exit that arrives while a restart is still counting is ignored.
  always @(posedge aclk) begin
    if (!aresetn) begin
      restart_busy_r <= 1'b0;
      restart_cnt_r <= 12'h000;
      cpu_resume <= 1'b0;
    end else begin
      cpu_resume <= 1'b0;
      if (stop_exit && !restart_busy_r) begin
        restart_busy_r <= 1'b1;
        restart_cnt_r <= options_r[`SCRC_OPT_STARTUP] ?
                         `SCRC_RESTART_LONG : `SCRC_RESTART_SHORT;
      end else if (restart_busy_r) begin
        if (restart_cnt_r == 12'h001) begin
          restart_busy_r <= 1'b0;
          cpu_resume <= 1'b1;
        end
        restart_cnt_r <= restart_cnt_r - 12'h001;
      end
    end
  end

  // Once forced monitoring has been on, it stays on until the next reset.
  // Special mode may clear the field again, but must not switch monitoring off.
  always @(posedge aclk) begin
    if (!aresetn) begin
      forced_seen_r <= 1'b0;
    end else if (options_r[`SCRC_OPT_MONFORCE]) begin
      forced_seen_r <= 1'b1;
    end
  end

  // Control outputs decoded from the options register and working latches.
  always @(posedge aclk) begin
    if (!aresetn) begin
      converter_power <= 1'b0;
      clock_source_select <= 1'b0;
      interrupt_pin_sense <= 1'b0;
      startup_delay_enable <= 1'b1;
      clock_monitor_active <= 1'b0;
      watchdog_rate <= 2'h0;
      watchdog_scale <= `SCRC_SCALE_1;
      watchdog_prescale_exp <= `SCRC_WDOG_EXP;
      aux_clock_pin <= 1'b0;
      aux_clock_pin_oe <= 1'b0;
      pullup_assign_enable <= 1'b0;
      security_disable <= 1'b0;
      watchdog_disable <= 1'b0;
      nonvolatile_map_enable <= 1'b0;
    end else begin
      converter_power <= options_r[`SCRC_OPT_CONV];
      clock_source_select <= options_r[`SCRC_OPT_CLKSRC];
      interrupt_pin_sense <= options_r[`SCRC_OPT_IRQS];
      startup_delay_enable <= options_r[`SCRC_OPT_STARTUP];
      // Forced monitoring overrides the free enable and holds until reset.
      clock_monitor_active <= options_r[`SCRC_OPT_MONEN] | options_r[`SCRC_OPT_MONFORCE] |
                              forced_seen_r;
      watchdog_rate <= options_r[`SCRC_OPT_RATE_HI:`SCRC_OPT_RATE_LO];
      watchdog_prescale_exp <= `SCRC_WDOG_EXP;
      case (options_r[`SCRC_OPT_RATE_HI:`SCRC_OPT_RATE_LO])
        2'h1: watchdog_scale <= `SCRC_SCALE_4;
        2'h2: watchdog_scale <= `SCRC_SCALE_16;
        2'h3: watchdog_scale <= `SCRC_SCALE_64;
        default: watchdog_scale <= `SCRC_SCALE_1;
      endcase
      aux_clock_pin <= aux_clock & config_r[`SCRC_CFG_AUXCLK];
      aux_clock_pin_oe <= config_r[`SCRC_CFG_AUXCLK];
      pullup_assign_enable <= config_r[`SCRC_CFG_PULLUP];
      security_disable <= config_r[`SCRC_CFG_NOSECURE];
      watchdog_disable <= config_r[`SCRC_CFG_NOWDOG];
      nonvolatile_map_enable <= config_r[`SCRC_CFG_NVMAP];
    end
  end

  // Reset effects on CPU, memory map, ports and timers.
  always @(posedge aclk) begin
    if (!aresetn) begin
      in_reset_r <= 1'b1;
      vector_addr <= `SCRC_VEC_PIN;
      vector_fetch <= 1'b0;
      condition_codes_mask_x <= 1'b1;
      condition_codes_mask_i <= 1'b1;
      condition_codes_stop_inhibit <= 1'b1;
      init_map <= `SCRC_INIT_MAP_RESET;
      ram_base <= `SCRC_RAM_BASE;
      ram_top <= `SCRC_RAM_TOP;
      reg_top <= `SCRC_REG_TOP;
      nv_base <= `SCRC_NV_BASE;
      nv_top <= `SCRC_NV_TOP;
      ports_bcf_to_bus <= expanded_mode;
      ports_all_inputs <= !expanded_mode;
      timer_init <= 1'b1;
      compare_init_value <= `SCRC_COMPARE_RESET;
      compare_one_output_mask <= 8'h00;
      capture4_compare5_select <= 1'b0;
      ext_clock_enable_a <= 1'b0;
      ext_clock_enable_b <= 1'b0;
      channel4_is_compare <= 1'b1;
    end else begin
      in_reset_r <= 1'b0;
      timer_init <= 1'b0;
      vector_fetch <= in_reset_r;
      if (in_reset_r) begin
        vector_addr <= vector_nxt;
      end
    end
  end

endmodule // scrc_top
`default_nettype wire

// ===== testbench/scrc_nv_model.sv
// Nonvolatile cell store and auxiliary clock source at the far side of the block.
`timescale 1ns/1ns
`default_nettype none
module scrc_nv_model #(parameter logic [7:0] CELLS_INIT = 8'h2c) (
  input wire logic aclk,
  input wire logic nv_prog_strobe,
  input wire logic [7:0] nv_prog_data,
  output logic [7:0] nv_cells,
  output logic aux_clock
);
  initial begin
    nv_cells = CELLS_INIT;
    aux_clock = 1'b0;
  end
  // Programming lands in the cells at once; the block only sees it at its next reset.
  always @(posedge aclk) begin
    if (nv_prog_strobe) nv_cells <= nv_prog_data;
    aux_clock <= ~aux_clock;
  end
endmodule // scrc_nv_model
`default_nettype wire

// ===== testbench/scrc_sva.sv
// Port-level assertion checker for the configuration and reset control block.
`timescale 1ns/1ns
`default_nettype none
module scrc_sva (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic startup_delay_enable,
  input wire logic clock_monitor_active,
  input wire logic [1:0] watchdog_rate,
  input wire logic [6:0] watchdog_scale,
  input wire logic [4:0] watchdog_prescale_exp,
  input wire logic vector_fetch,
  input wire logic [15:0] vector_addr,
  input wire logic ports_bcf_to_bus,
  input wire logic ports_all_inputs,
  input wire logic aux_clock,
  input wire logic aux_clock_pin,
  input wire logic aux_clock_pin_oe,
  input wire logic stop_exit,
  input wire logic cpu_resume,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic nv_prog_strobe
);
  // All checks share the bus clock and rest while reset is held.
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_reset_state: assert property ($rose(aresetn) |->
    startup_delay_enable && !clock_monitor_active && watchdog_rate == 2'h0)
    else $error("options not at reset state");
  a_vector_pulse: assert property ($rose(aresetn) |=> vector_fetch ##1 !vector_fetch)
    else $error("vector fetch pulse wrong");
  a_vector_code: assert property (vector_fetch |->
    vector_addr[7:0] inside {8'hfe, 8'hfc, 8'hfa} && vector_addr[15:8] inside {8'hff, 8'hbf})
    else $error("vector address wrong");
  a_rate_scale: assert property (watchdog_prescale_exp == 5'h0f &&
    watchdog_scale == (7'h01 << {watchdog_rate, 1'b0}))
    else $error("watchdog scale wrong");
  a_ports_mode: assert property (ports_all_inputs != ports_bcf_to_bus)
    else $error("port mode outputs agree");
  a_aux_follow: assert property (aux_clock_pin_oe && $past(aux_clock_pin_oe) && $past(aresetn) |->
    aux_clock_pin == $past(aux_clock))
    else $error("aux pin does not follow clock");
  a_resume_fast: assert property (stop_exit && !startup_delay_enable |-> ##[3:5] cpu_resume)
    else $error("short restart too slow");
  a_b_clear: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer not cleared");
  // Main scenarios seen at least once.
  c_fetch: cover property (vector_fetch);
  c_resume: cover property (cpu_resume);
  c_prog: cover property (nv_prog_strobe);
endmodule // scrc_sva
bind scrc_top scrc_sva chk (.*);
`default_nettype wire

// ===== testbench/system_config_reset_control_tb.sv
// Self-checking bench for the configuration and reset control block.
`timescale 1ns/1ns
`default_nettype none
`include "scrc_map.vh"
module system_config_reset_control_tb;
  localparam logic [11:0] A_OPT = {`SCRC_IDX_OPTIONS, 2'b00};
  localparam logic [11:0] A_CFG = {`SCRC_IDX_CONFIG, 2'b00};
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, special_mode_flag;
  logic expanded_mode, stop_exit, aux_clock, nv_prog_strobe, cpu_resume, converter_power;
  logic clock_source_select, interrupt_pin_sense, startup_delay_enable, clock_monitor_active;
  logic aux_clock_pin, aux_clock_pin_oe, pullup_assign_enable, security_disable, watchdog_disable;
  logic nonvolatile_map_enable, vector_fetch, condition_codes_mask_x, condition_codes_mask_i;
  logic condition_codes_stop_inhibit;
  logic ports_bcf_to_bus, ports_all_inputs, timer_init, capture4_compare5_select;
  logic ext_clock_enable_a, ext_clock_enable_b, channel4_is_compare, hs;
  logic [1:0] s_axi_bresp, s_axi_rresp, reset_cause, watchdog_rate;
  logic [2:0] s_axi_awprot, s_axi_arprot;
  logic [3:0] s_axi_wstrb;
  logic [4:0] watchdog_prescale_exp;
  logic [6:0] watchdog_scale;
  logic [7:0] nv_cells, nv_prog_data, init_map, compare_one_output_mask, d;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [15:0] vector_addr, ram_base, ram_top, reg_top, nv_base, nv_top, compare_init_value;
  logic [31:0] s_axi_wdata, s_axi_rdata, lfsr;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  logic [15:0] vq[$];
  logic [7:0] nq[$];
  int n_fail = 0, compares = 0, cyc = 0, n;
  scrc_top dut (.*);
  scrc_nv_model #(.CELLS_INIT(8'h2c)) nv (.*);
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  task check(input logic [33:0] s, input logic [33:0] e);
    compares++;
    if (s !== e) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task print_verdict;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  function automatic logic [31:0] lfsr_next(input logic [31:0] x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h04000007 : 32'h0);
  endfunction
  // Samples a line between edges and returns at the edge that takes it, counting cycles.
  task automatic wait_hi(ref logic s);
    hs = 1'b0;
    n = 0;
    while (!hs) begin
      @(negedge aclk);
      hs = s;
      n++;
      @(posedge aclk);
    end
  endtask
  task do_reset(input logic [1:0] c, input logic s, input logic e);
    reset_cause <= c;
    special_mode_flag <= s;
    expanded_mode <= e;
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    vq.push_back({s ? 8'hbf : 8'hff, c == 2'h1 ? 8'hfc : c == 2'h2 ? 8'hfa : 8'hfe});
  endtask
  // Address and data go out together; each is dropped at the edge that takes it.
  task wr(input logic [11:0] a, input logic [7:0] v, input logic [1:0] r);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    bq.push_back(r);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, v};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(ad && wd)) begin
      @(negedge aclk);
      ad = ad || (s_axi_awvalid && s_axi_awready);
      wd = wd || (s_axi_wvalid && s_axi_wready);
      @(posedge aclk);
      if (ad) s_axi_awvalid <= 1'b0;
      if (wd) s_axi_wvalid <= 1'b0;
    end
    wait_hi(s_axi_bvalid);
    s_axi_bready <= 1'b0;
    // Let an edge pass so that a following call never drives the same strobe in this step.
    @(posedge aclk);
  endtask
  task rd(input logic [11:0] a, input logic [7:0] v);
    rq.push_back({2'h0, 24'h0, v});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    wait_hi(s_axi_arready);
    s_axi_arvalid <= 1'b0;
    wait_hi(s_axi_rvalid);
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask
  task restart;
    stop_exit <= 1'b1;
    @(posedge aclk);
    stop_exit <= 1'b0;
    wait_hi(cpu_resume);
  endtask
  // Pairs each answer or pulse with its oldest noted expectation, and bounds the run.
  always @(posedge aclk) begin
    if (s_axi_rvalid && s_axi_rready) check({s_axi_rresp, s_axi_rdata}, rq.size() ? rq.pop_front() : 'x);
    if (s_axi_bvalid && s_axi_bready) check(s_axi_bresp, bq.size() ? bq.pop_front() : 'x);
    if (vector_fetch) check(vector_addr, vq.size() ? vq.pop_front() : 'x);
    if (nv_prog_strobe) check(nv_prog_data, nq.size() ? nq.pop_front() : 'x);
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      print_verdict;
    end
  end
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {stop_exit, special_mode_flag, expanded_mode, reset_cause} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awprot, s_axi_arprot} = '0;
    s_axi_wstrb = 4'hf;
    lfsr = lfsr_next(32'h574d79ae);
    d = lfsr[7:0];
    do_reset(2'h0, 1'b0, 1'b0);
    rd(A_OPT, `SCRC_OPT_RESET);
    rd(A_CFG, 8'hee);
    check({ram_base, ram_top}, {16'h00a0, 16'h039f});
    check({compare_one_output_mask, capture4_compare5_select, channel4_is_compare}, 10'h001);
    check({ext_clock_enable_a, ext_clock_enable_b}, 2'h0);
    check({condition_codes_mask_x, condition_codes_mask_i}, 2'h3);
    check({init_map, reg_top}, {8'h00, 16'h009f});
    check({nv_base, nv_top}, {16'h0d80, 16'h0fff});
    check({compare_init_value, condition_codes_stop_inhibit}, {16'hffff, 1'b1});
    check({timer_init, ports_all_inputs}, 2'h1);
    wr(A_OPT, 8'hff, `SCRC_RESP_OKAY);
    rd(A_OPT, 8'hff);
    wr(A_OPT, 8'h00, `SCRC_RESP_OKAY);
    rd(A_OPT, 8'h37);
    check({converter_power, clock_source_select, interrupt_pin_sense, startup_delay_enable}, 4'h3);
    check({clock_monitor_active, watchdog_rate}, 3'h7);
    wr(12'h000, 8'h00, `SCRC_RESP_SLVERR);
    nq.push_back(d);
    wr(A_CFG, d, `SCRC_RESP_OKAY);
    rd(A_CFG, 8'hee);
    do_reset(2'h1, 1'b0, 1'b1);
    rd(A_CFG, d | 8'hc2);
    check({aux_clock_pin_oe, pullup_assign_enable, security_disable, watchdog_disable}, d[5:2]);
    check({nonvolatile_map_enable, ports_bcf_to_bus}, {d[0], 1'b1});
    repeat (70) @(posedge aclk);
    wr(A_OPT, 8'hff, `SCRC_RESP_OKAY);
    rd(A_OPT, 8'hd8);
    check(clock_monitor_active, 1'b1);
    do_reset(2'h2, 1'b1, 1'b0);
    wr(A_CFG, 8'h00, `SCRC_RESP_OKAY);
    rd(A_CFG, 8'hc2);
    wr(A_CFG, 8'h20, `SCRC_RESP_OKAY);
    rd(A_CFG, 8'he2);
    check({aux_clock_pin_oe, pullup_assign_enable}, 2'h2);
    wr(A_OPT, 8'h37, `SCRC_RESP_OKAY);
    wr(A_OPT, 8'h01, `SCRC_RESP_OKAY);
    rd(A_OPT, 8'h01);
    check(clock_monitor_active, 1'b1);
    restart;
    check(n >= 3 && n <= 6, 1'b1);
    wr(A_OPT, 8'h15, `SCRC_RESP_OKAY);
    restart;
    check(n >= `SCRC_RESTART_LONG - 1 && n <= `SCRC_RESTART_LONG + 2, 1'b1);
    check(rq.size() + bq.size() + vq.size() + nq.size(), 0);
    print_verdict;
  end
endmodule // system_config_reset_control_tb
`default_nettype wire
